/* verilog/link_host_register_bank.sv */
// configuration and memory-mapped register bank of the link host controller
module link_host_register_bank (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// reset pins
	input wire logic pcie_reset_n,
	input wire logic global_reset_n,
	output logic fundamental_reset_n,
	// configuration access
	input wire logic cfg_wr_en,
	input wire logic cfg_rd_en,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	// memory access
	input wire logic mem_wr_en,
	input wire logic mem_rd_en,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_rvalid,
	output logic mem_hit,
	// link status
	input wire logic [31:0] int_event_in,
	input wire logic [31:0] pw_addr_lo_in,
	input wire logic [31:0] pw_addr_hi_in,
	input wire logic [31:0] sid_count_in,
	// control outputs
	output logic dv_timestamp_boost_en,
	output logic priority_arb_en,
	output logic accel_phy_notify,
	output logic [15:0] subsystem_device_alias,
	output logic [15:0] subsystem_maker_alias,
	output logic [31:0] host_ctrl_value,
	output logic [31:0] iso_rx_mask_hi,
	output logic [31:0] iso_rx_mask_lo,
	output logic [31:0] int_event_value,
	output logic [31:0] int_mask_value
);

	// ************************************************************
	// fundamental reset
	// ************************************************************
	logic pins_n;
	logic [2:0] fundamental_reset_n_sync_ff;

	// asserts at once with either pin, releases on the clock
	assign pins_n = pcie_reset_n & global_reset_n;

	always_ff @(posedge sys_clk or negedge pins_n) begin
		if (!pins_n) begin
			fundamental_reset_n_sync_ff <= 3'h0;
		end else begin
			fundamental_reset_n_sync_ff <= {fundamental_reset_n_sync_ff[1:0], 1'b1};
		end
	end

	// release counts only once the last two stages agree
	logic fundamental_reset_n_n;
	assign fundamental_reset_n_n = fundamental_reset_n_sync_ff[2] & fundamental_reset_n_sync_ff[1];

	always_ff @(posedge sys_clk or negedge pins_n) begin
		if (!pins_n) begin
			fundamental_reset_n <= 1'b0;
		end else begin
			fundamental_reset_n <= fundamental_reset_n_n;
		end
	end

	// ************************************************************
	// address decode helpers
	// ************************************************************
	// maps a window offset to a storage slot, or none
	function automatic logic [3:0] rw_slot(input logic [10:0] off);
		logic [3:0] s;
		s = link_host_pkg::RW_NONE;
		case (off)
			link_host_pkg::OFF_UID_ROM: s = 4'h0;
			link_host_pkg::OFF_AT_RETRY: s = 4'h1;
			link_host_pkg::OFF_LOCK_DATA: s = 4'h2;
			link_host_pkg::OFF_LOCK_CMP: s = 4'h3;
			link_host_pkg::OFF_LOCK_CTRL: s = 4'h4;
			link_host_pkg::OFF_CROM_HDR: s = 4'h5;
			link_host_pkg::OFF_BUS_OPT: s = 4'h6;
			link_host_pkg::OFF_CROM_MAP: s = 4'h7;
			link_host_pkg::OFF_SID_BUF: s = 4'h8;
			default: s = link_host_pkg::RW_NONE;
		endcase
		return s;
	endfunction : rw_slot

	// write strobe for one pair address
	function automatic logic pair_we(input logic we, input logic [10:0] off,
		input logic [10:0] target);
		return we && (off == target);
	endfunction : pair_we

	// ************************************************************
	// base address register
	// ************************************************************
	logic [31:0] bar_ff;
	logic cfg_bar_we;
	assign cfg_bar_we = cfg_wr_en && (cfg_addr == link_host_pkg::CFG_BAR_OFF);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bar_ff <= 32'h00000000;
		end else if (cfg_bar_we) begin
			bar_ff <= cfg_wdata & link_host_pkg::BAR_ADDR_MASK;
		end
	end

	logic win_hit;
	logic [10:0] win_off;
	// whole 2k window selected by the upper address bits
	// the two low address bits take part, so unaligned words miss every register
	assign win_hit = (mem_addr & link_host_pkg::BAR_ADDR_MASK) == bar_ff;
	assign win_off = mem_addr[link_host_pkg::WIN_ADDR_BITS-1:0];

	logic mem_we;
	assign mem_we = mem_wr_en && win_hit;

	// ************************************************************
	// link enhancement control and subsystem alias
	// ************************************************************
	logic [31:0] lec_ff;
	logic [31:0] subsys_ff;
	logic cfg_lec_we;
	logic cfg_alias_we;
	assign cfg_lec_we = cfg_wr_en && (cfg_addr == link_host_pkg::CFG_LINK_ENH_OFF);
	assign cfg_alias_we = cfg_wr_en && (cfg_addr == link_host_pkg::CFG_SUBSYS_ALIAS_OFF);

	// sticky fields: only the reset pins clear them, never resetn
	always_ff @(posedge sys_clk or negedge fundamental_reset_n_n) begin
		if (!fundamental_reset_n_n) begin
			lec_ff <= link_host_pkg::LEC_RESET;
		end else if (cfg_lec_we) begin
			// only bits 8, 7, 2 and 1 hold; the rest stay zero
			lec_ff <= cfg_wdata & link_host_pkg::LEC_WRITE_MASK;
		end
	end

	always_ff @(posedge sys_clk or negedge fundamental_reset_n_n) begin
		if (!fundamental_reset_n_n) begin
			subsys_ff <= link_host_pkg::SUBSYS_RESET;
		end else if (cfg_alias_we) begin
			subsys_ff <= cfg_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge fundamental_reset_n_n) begin
		if (!fundamental_reset_n_n) begin
			dv_timestamp_boost_en <= 1'b0;
			priority_arb_en <= 1'b0;
			accel_phy_notify <= 1'b0;
			subsystem_device_alias <= 16'h0000;
			subsystem_maker_alias <= 16'h0000;
		end else begin
			dv_timestamp_boost_en <= lec_ff[link_host_pkg::LEC_DV_TS_BIT];
			priority_arb_en <= lec_ff[link_host_pkg::LEC_PRIO_BIT];
			accel_phy_notify <= lec_ff[link_host_pkg::LEC_ACCEL_BIT];
			subsystem_device_alias <=
				subsys_ff[link_host_pkg::SUBSYS_DEV_MSB:link_host_pkg::SUBSYS_DEV_LSB];
			subsystem_maker_alias <=
				subsys_ff[link_host_pkg::SUBSYS_MAKER_MSB:link_host_pkg::SUBSYS_MAKER_LSB];
		end
	end

	// ************************************************************
	// configuration read
	// ************************************************************
	logic [31:0] nxt_cfg_rdata;

	always_comb begin
		case (cfg_addr)
			link_host_pkg::CFG_BAR_OFF: nxt_cfg_rdata = bar_ff;
			link_host_pkg::CFG_LINK_ENH_OFF: nxt_cfg_rdata = lec_ff;
			link_host_pkg::CFG_SUBSYS_ALIAS_OFF: nxt_cfg_rdata = subsys_ff;
			default: nxt_cfg_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cfg_rdata <= 32'h00000000;
			cfg_rvalid <= 1'b0;
		end else begin
			cfg_rvalid <= cfg_rd_en;
			if (cfg_rd_en) begin
				cfg_rdata <= nxt_cfg_rdata;
			end
		end
	end

	// ************************************************************
	// plain storage registers
	// ************************************************************
	// whole-word writes only; there are no byte enables
	logic [31:0] rw_file_ff [link_host_pkg::RW_COUNT];
	logic [3:0] wr_slot;
	logic [3:0] rd_slot;
	assign wr_slot = rw_slot(win_off);
	assign rd_slot = rw_slot(win_off);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < link_host_pkg::RW_COUNT; i++) begin
				rw_file_ff[i] <= link_host_pkg::RW_RESET;
			end
		end else if (mem_we && wr_slot != link_host_pkg::RW_NONE) begin
			rw_file_ff[wr_slot] <= mem_wdata;
		end
	end

	// ************************************************************
	// set/clear pairs
	// ************************************************************
	// host control survives a soft reset, hence the fundamental reset
	set_clear_reg u_host_ctrl (
		.clk(sys_clk),
		.rst_n(fundamental_reset_n_n),
		.set_we(pair_we(mem_we, win_off, link_host_pkg::OFF_HC_SET)),
		.clr_we(pair_we(mem_we, win_off, link_host_pkg::OFF_HC_CLR)),
		.wdata(mem_wdata),
		.hw_set(32'h00000000),
		.value_ff(host_ctrl_value)
	);

	set_clear_reg u_iso_mask_hi (
		.clk(sys_clk),
		.rst_n(resetn),
		.set_we(pair_we(mem_we, win_off, link_host_pkg::OFF_IRM_HI_SET)),
		.clr_we(pair_we(mem_we, win_off, link_host_pkg::OFF_IRM_HI_CLR)),
		.wdata(mem_wdata),
		.hw_set(32'h00000000),
		.value_ff(iso_rx_mask_hi)
	);

	set_clear_reg u_iso_mask_lo (
		.clk(sys_clk),
		.rst_n(resetn),
		.set_we(pair_we(mem_we, win_off, link_host_pkg::OFF_IRM_LO_SET)),
		.clr_we(pair_we(mem_we, win_off, link_host_pkg::OFF_IRM_LO_CLR)),
		.wdata(mem_wdata),
		.hw_set(32'h00000000),
		.value_ff(iso_rx_mask_lo)
	);

	// events from the link set bits; set beats a same-cycle clear
	set_clear_reg u_int_event (
		.clk(sys_clk),
		.rst_n(resetn),
		.set_we(pair_we(mem_we, win_off, link_host_pkg::OFF_INT_EV_SET)),
		.clr_we(pair_we(mem_we, win_off, link_host_pkg::OFF_INT_EV_CLR)),
		.wdata(mem_wdata),
		.hw_set(int_event_in),
		.value_ff(int_event_value)
	);

	set_clear_reg u_int_mask (
		.clk(sys_clk),
		.rst_n(resetn),
		.set_we(pair_we(mem_we, win_off, link_host_pkg::OFF_INT_MASK_SET)),
		.clr_we(pair_we(mem_we, win_off, link_host_pkg::OFF_INT_MASK_CLR)),
		.wdata(mem_wdata),
		.hw_set(32'h00000000),
		.value_ff(int_mask_value)
	);

	// ************************************************************
	// memory read
	// ************************************************************
	// gaps in the map and the unused tail of the window read zero
	logic [31:0] nxt_mem_rdata;

	always_comb begin
		nxt_mem_rdata = 32'h00000000;
		if (rd_slot != link_host_pkg::RW_NONE) begin
			nxt_mem_rdata = rw_file_ff[rd_slot];
		end else begin
			case (win_off)
				link_host_pkg::OFF_VERSION: nxt_mem_rdata = link_host_pkg::VERSION_VALUE;
				link_host_pkg::OFF_BUS_ID: nxt_mem_rdata = link_host_pkg::BUS_ID_VALUE;
				link_host_pkg::OFF_UID_HI: nxt_mem_rdata = link_host_pkg::UID_HI_VALUE;
				link_host_pkg::OFF_UID_LO: nxt_mem_rdata = link_host_pkg::UID_LO_VALUE;
				link_host_pkg::OFF_PW_ADDR_LO: nxt_mem_rdata = pw_addr_lo_in;
				link_host_pkg::OFF_PW_ADDR_HI: nxt_mem_rdata = pw_addr_hi_in;
				link_host_pkg::OFF_MAKER_ID: nxt_mem_rdata = link_host_pkg::MAKER_ID_VALUE;
				link_host_pkg::OFF_SID_CNT: nxt_mem_rdata = sid_count_in;
				link_host_pkg::OFF_HC_SET,
				link_host_pkg::OFF_HC_CLR: nxt_mem_rdata = host_ctrl_value;
				link_host_pkg::OFF_IRM_HI_SET,
				link_host_pkg::OFF_IRM_HI_CLR: nxt_mem_rdata = iso_rx_mask_hi;
				link_host_pkg::OFF_IRM_LO_SET,
				link_host_pkg::OFF_IRM_LO_CLR: nxt_mem_rdata = iso_rx_mask_lo;
				link_host_pkg::OFF_INT_EV_SET: nxt_mem_rdata = int_event_value;
				// at the clear address software sees only the events it has unmasked
				link_host_pkg::OFF_INT_EV_CLR:
					nxt_mem_rdata = int_event_value & int_mask_value;
				link_host_pkg::OFF_INT_MASK_SET,
				link_host_pkg::OFF_INT_MASK_CLR: nxt_mem_rdata = int_mask_value;
				default: nxt_mem_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mem_rdata <= 32'h00000000;
			mem_rvalid <= 1'b0;
			mem_hit <= 1'b0;
		end else begin
			mem_rvalid <= mem_rd_en && win_hit;
			mem_hit <= (mem_rd_en || mem_wr_en) && win_hit;
			if (mem_rd_en && win_hit) begin
				mem_rdata <= nxt_mem_rdata;
			end
		end
	end

endmodule : link_host_register_bank

/* verilog/link_host_pkg.sv */
// constants shared by the link host register bank
package link_host_pkg;

	// ************************************************************
	// configuration space offsets
	// ************************************************************
	localparam logic [7:0] CFG_BAR_OFF = 8'h10;
	localparam logic [7:0] CFG_LINK_ENH_OFF = 8'hf4;
	localparam logic [7:0] CFG_SUBSYS_ALIAS_OFF = 8'hf8;

	// ************************************************************
	// memory window
	// ************************************************************
	localparam int WIN_ADDR_BITS = 11;
	localparam logic [31:0] BAR_ADDR_MASK = 32'hfffff800;

	// ************************************************************
	// link enhancement control fields
	// ************************************************************
	localparam int LEC_DV_TS_BIT = 8;
	localparam int LEC_PRIO_BIT = 7;
	localparam int LEC_KEEP_ZERO_BIT = 2;
	localparam int LEC_ACCEL_BIT = 1;
	localparam logic [31:0] LEC_WRITE_MASK = 32'h00000186;
	localparam logic [31:0] LEC_RESET = 32'h00000000;

	// ************************************************************
	// subsystem alias fields
	// ************************************************************
	localparam int SUBSYS_DEV_MSB = 31;
	localparam int SUBSYS_DEV_LSB = 16;
	localparam int SUBSYS_MAKER_MSB = 15;
	localparam int SUBSYS_MAKER_LSB = 0;
	localparam logic [31:0] SUBSYS_RESET = 32'h00000000;

	// ************************************************************
	// memory-mapped register offsets
	// ************************************************************
	localparam logic [10:0] OFF_VERSION = 11'h000;
	localparam logic [10:0] OFF_UID_ROM = 11'h004;
	localparam logic [10:0] OFF_AT_RETRY = 11'h008;
	localparam logic [10:0] OFF_LOCK_DATA = 11'h00c;
	localparam logic [10:0] OFF_LOCK_CMP = 11'h010;
	localparam logic [10:0] OFF_LOCK_CTRL = 11'h014;
	localparam logic [10:0] OFF_CROM_HDR = 11'h018;
	localparam logic [10:0] OFF_BUS_ID = 11'h01c;
	localparam logic [10:0] OFF_BUS_OPT = 11'h020;
	localparam logic [10:0] OFF_UID_HI = 11'h024;
	localparam logic [10:0] OFF_UID_LO = 11'h028;
	localparam logic [10:0] OFF_CROM_MAP = 11'h034;
	localparam logic [10:0] OFF_PW_ADDR_LO = 11'h038;
	localparam logic [10:0] OFF_PW_ADDR_HI = 11'h03c;
	localparam logic [10:0] OFF_MAKER_ID = 11'h040;
	localparam logic [10:0] OFF_HC_SET = 11'h050;
	localparam logic [10:0] OFF_HC_CLR = 11'h054;
	localparam logic [10:0] OFF_SID_BUF = 11'h064;
	localparam logic [10:0] OFF_SID_CNT = 11'h068;
	localparam logic [10:0] OFF_IRM_HI_SET = 11'h070;
	localparam logic [10:0] OFF_IRM_HI_CLR = 11'h074;
	localparam logic [10:0] OFF_IRM_LO_SET = 11'h078;
	localparam logic [10:0] OFF_IRM_LO_CLR = 11'h07c;
	localparam logic [10:0] OFF_INT_EV_SET = 11'h080;
	localparam logic [10:0] OFF_INT_EV_CLR = 11'h084;
	localparam logic [10:0] OFF_INT_MASK_SET = 11'h088;
	localparam logic [10:0] OFF_INT_MASK_CLR = 11'h08c;

	// ************************************************************
	// plain storage registers and reset values
	// ************************************************************
	localparam int RW_COUNT = 9;
	localparam logic [3:0] RW_NONE = 4'hf;
	localparam logic [31:0] RW_RESET = 32'h00000000;
	localparam logic [31:0] PAIR_RESET = 32'h00000000;

	// arbitrary identity values, not taken from any real part
	localparam logic [31:0] VERSION_VALUE = 32'h00000001;
	localparam logic [31:0] MAKER_ID_VALUE = 32'h00000000;
	localparam logic [31:0] BUS_ID_VALUE = 32'h00000000;
	localparam logic [31:0] UID_HI_VALUE = 32'h00000000;
	localparam logic [31:0] UID_LO_VALUE = 32'h00000000;

endpackage : link_host_pkg

/* verilog/set_clear_reg.sv */
// one set/clear register with a hardware event input
module set_clear_reg (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// software access
	input wire logic set_we,
	input wire logic clr_we,
	input wire logic [31:0] wdata,
	// hardware events
	input wire logic [31:0] hw_set,
	// contents
	output logic [31:0] value_ff
);

	logic [31:0] nxt_value;

	always_comb begin
		nxt_value = value_ff;
		if (set_we) begin
			nxt_value = nxt_value | wdata;
		end
		if (clr_we) begin
			nxt_value = nxt_value & ~wdata;
		end
		// an event in the clearing cycle must not be lost
		nxt_value = nxt_value | hw_set;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			value_ff <= link_host_pkg::PAIR_RESET;
		end else begin
			value_ff <= nxt_value;
		end
	end

endmodule : set_clear_reg

/* testbench/link_host_register_bank_properties.sv */
// concurrent checks on the ports of the link host register bank
module link_host_regs_checker (
	// clock and resets
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic pcie_reset_n,
	input wire logic global_reset_n,
	input wire logic fundamental_reset_n,
	// configuration access
	input wire logic cfg_wr_en,
	input wire logic cfg_rd_en,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_rvalid,
	// memory access
	input wire logic mem_wr_en,
	input wire logic mem_rd_en,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_rvalid,
	input wire logic mem_hit,
	// register copies
	input wire logic dv_timestamp_boost_en,
	input wire logic priority_arb_en,
	input wire logic accel_phy_notify,
	input wire logic [15:0] subsystem_device_alias,
	input wire logic [15:0] subsystem_maker_alias,
	input wire logic [31:0] host_ctrl_value,
	input wire logic [31:0] iso_rx_mask_hi,
	input wire logic [31:0] iso_rx_mask_lo,
	input wire logic [31:0] int_event_value,
	input wire logic [31:0] int_mask_value
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	// ************************************************************
	// sequences
	// ************************************************************
	// a window write that has just been accepted at this offset
	sequence win_wr_s(logic [10:0] off);
		mem_hit && $past(mem_wr_en) && ($past(mem_addr[10:0]) == off);
	endsequence
	sequence cfg_rd_s(logic [7:0] off);
		cfg_rd_en && (cfg_addr == off) && fundamental_reset_n;
	endsequence

	// ************************************************************
	// assertions
	// ************************************************************
	fundamental_reset_n_follows_pins_a: assert property (
		(!pcie_reset_n || !global_reset_n) |-> !fundamental_reset_n)
		else $error("fundamental reset not low with a pin low");
	lec_reserved_zero_a: assert property (
		cfg_rd_s(8'hf4) |=> cfg_rvalid && ((cfg_rdata & 32'hfffffe79) == 32'h0))
		else $error("enhancement reserved bits not zero");
	alias_read_back_a: assert property (
		cfg_rd_s(8'hf8) |=>
		cfg_rvalid && (cfg_rdata == {subsystem_device_alias, subsystem_maker_alias}))
		else $error("alias read differs from copies");
	lec_copy_follows_a: assert property (
		(cfg_wr_en && (cfg_addr == 8'hf4) && fundamental_reset_n) |-> ##2
		({dv_timestamp_boost_en, priority_arb_en, accel_phy_notify} ==
		{$past(cfg_wdata[8], 2), $past(cfg_wdata[7], 2), $past(cfg_wdata[1], 2)}))
		else $error("enhancement enables not updated");
	hc_set_bits_a: assert property (
		win_wr_s(11'h050) |-> host_ctrl_value == ($past(host_ctrl_value) | $past(mem_wdata)))
		else $error("host control set wrong");
	hc_clear_bits_a: assert property (
		win_wr_s(11'h054) |-> host_ctrl_value == ($past(host_ctrl_value) & ~$past(mem_wdata)))
		else $error("host control clear wrong");
	iso_hi_clear_a: assert property (
		win_wr_s(11'h074) |-> iso_rx_mask_hi == ($past(iso_rx_mask_hi) & ~$past(mem_wdata)))
		else $error("iso mask high clear wrong");
	iso_lo_set_a: assert property (
		win_wr_s(11'h078) |-> iso_rx_mask_lo == ($past(iso_rx_mask_lo) | $past(mem_wdata)))
		else $error("iso mask low set wrong");
	mem_answer_hit_a: assert property (
		mem_rvalid |-> mem_hit && $past(mem_rd_en))
		else $error("read answer without window read");
	masked_clear_read_a: assert property (
		mem_rvalid && ($past(mem_addr[10:0]) == 11'h084) |->
		mem_rdata == ($past(int_event_value) & $past(int_mask_value)))
		else $error("event clear read not masked");
endmodule : link_host_regs_checker

bind link_host_register_bank link_host_regs_checker checker_i (.sys_clk(sys_clk), .resetn(resetn),
	.pcie_reset_n(pcie_reset_n), .global_reset_n(global_reset_n),
	.fundamental_reset_n(fundamental_reset_n), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
	.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
	.mem_wr_en(mem_wr_en), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
	.mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .mem_hit(mem_hit),
	.dv_timestamp_boost_en(dv_timestamp_boost_en), .priority_arb_en(priority_arb_en),
	.accel_phy_notify(accel_phy_notify), .subsystem_device_alias(subsystem_device_alias),
	.subsystem_maker_alias(subsystem_maker_alias), .host_ctrl_value(host_ctrl_value),
	.iso_rx_mask_hi(iso_rx_mask_hi), .iso_rx_mask_lo(iso_rx_mask_lo),
	.int_event_value(int_event_value), .int_mask_value(int_mask_value));

/* testbench/tb.sv */
// self-checking bench for the link host register bank
module tb;
	timeunit 1ns;
	timeprecision 1ns;

	`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
		$display("Error %0t: got %h expected %h", $time, (got), (exp)); end end

	typedef struct packed {logic m; logic w; logic [31:0] a; logic [31:0] d;} row_t;

	logic sys_clk = 1'b0, resetn = 1'b0, pcie_reset_n = 1'b0, global_reset_n = 1'b0;
	logic cfg_wr_en = 1'b0, cfg_rd_en = 1'b0, mem_wr_en = 1'b0, mem_rd_en = 1'b0;
	logic [7:0] cfg_addr = 8'h00;
	logic [31:0] cfg_wdata = 32'h0, mem_addr = 32'h0, mem_wdata = 32'h0, int_event_in = 32'h0;
	logic [31:0] cfg_rdata, mem_rdata, host_ctrl_value, iso_rx_mask_hi, q;
	logic cfg_rvalid, mem_rvalid, mem_hit, fundamental_reset_n, v;
	logic dv_timestamp_boost_en, priority_arb_en, accel_phy_notify;
	logic [15:0] subsystem_device_alias, subsystem_maker_alias;
	int bad_count = 0, compares = 0, cycles = 0;

	// window moved to 1000h by the table, so a miss at 50h stays outside it
	localparam row_t ROWS [24] = '{
		'{1'b0, 1'b0, 32'hf8, 32'h0}, '{1'b0, 1'b1, 32'hf4, 32'hfffffffb},
		'{1'b0, 1'b0, 32'hf4, 32'h00000182}, '{1'b0, 1'b1, 32'hf8, 32'ha5a55a5a},
		'{1'b0, 1'b0, 32'hf8, 32'ha5a55a5a}, '{1'b0, 1'b1, 32'h10, 32'h000017ff},
		'{1'b0, 1'b0, 32'h10, 32'h00001000}, '{1'b1, 1'b0, 32'h00001000, link_host_pkg::VERSION_VALUE},
		'{1'b1, 1'b1, 32'h00001008, 32'hdeadbeef}, '{1'b1, 1'b0, 32'h00001008, 32'hdeadbeef},
		'{1'b1, 1'b1, 32'h00001050, 32'h0000000f}, '{1'b1, 1'b1, 32'h00001054, 32'h00000005},
		'{1'b1, 1'b0, 32'h00001050, 32'h0000000a}, '{1'b1, 1'b0, 32'h00001054, 32'h0000000a},
		'{1'b1, 1'b1, 32'h00001070, 32'hf0f0f0f0}, '{1'b1, 1'b1, 32'h00001074, 32'h30303030},
		'{1'b1, 1'b0, 32'h00001070, 32'hc0c0c0c0}, '{1'b1, 1'b1, 32'h00001078, 32'h000000ff},
		'{1'b1, 1'b1, 32'h0000107c, 32'h0000000f}, '{1'b1, 1'b0, 32'h0000107c, 32'h000000f0},
		'{1'b1, 1'b1, 32'h0000102c, 32'h11111111}, '{1'b1, 1'b0, 32'h0000102c, 32'h0},
		'{1'b1, 1'b0, 32'h00001038, 32'h13572468}, '{1'b1, 1'b1, 32'h00001088, 32'h0000000f}};

	link_host_register_bank link_host_register_bank_i (.sys_clk(sys_clk), .resetn(resetn),
		.pcie_reset_n(pcie_reset_n), .global_reset_n(global_reset_n),
		.fundamental_reset_n(fundamental_reset_n), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
		.mem_wr_en(mem_wr_en), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .mem_hit(mem_hit),
		.int_event_in(int_event_in), .pw_addr_lo_in(32'h13572468), .pw_addr_hi_in(32'h24681357),
		.sid_count_in(32'h00000c30), .dv_timestamp_boost_en(dv_timestamp_boost_en),
		.priority_arb_en(priority_arb_en), .accel_phy_notify(accel_phy_notify),
		.subsystem_device_alias(subsystem_device_alias),
		.subsystem_maker_alias(subsystem_maker_alias), .host_ctrl_value(host_ctrl_value),
		.iso_rx_mask_hi(iso_rx_mask_hi), .iso_rx_mask_lo(), .int_event_value(),
		.int_mask_value());

	always #50 sys_clk = ~sys_clk;

	// ************************************************************
	// access and closing tasks
	// ************************************************************
	// one request per call; q and v are sampled in the answer cycle
	task automatic access(input logic m, input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		if (m) begin
			mem_wr_en <= w;
			mem_rd_en <= !w;
			mem_addr <= a;
			mem_wdata <= d;
		end else begin
			cfg_wr_en <= w;
			cfg_rd_en <= !w;
			cfg_addr <= a[7:0];
			cfg_wdata <= d;
		end
		@(posedge sys_clk);
		{mem_wr_en, mem_rd_en, cfg_wr_en, cfg_rd_en} <= 4'h0;
		#1;
		q = m ? mem_rdata : cfg_rdata;
		v = m ? (w ? mem_hit : mem_rvalid) : cfg_rvalid;
	endtask : access

	task automatic give_verdict();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			give_verdict();
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (3) @(posedge sys_clk);
		{resetn, pcie_reset_n, global_reset_n} <= 3'b111;
		repeat (6) @(posedge sys_clk);
		foreach (ROWS[i]) begin
			access(ROWS[i].m, ROWS[i].w, ROWS[i].a, ROWS[i].d);
			if (!ROWS[i].w) begin
				`CHK(q, ROWS[i].d)
				`CHK(v, 1'b1)
			end
		end
		`CHK({dv_timestamp_boost_en, priority_arb_en, accel_phy_notify}, 3'b111)
		`CHK(subsystem_maker_alias, 16'h5a5a)
		// a write at 50h, below the window at 1000h, must be ignored
		access(1'b1, 1'b1, 32'h00000050, 32'hffffffff);
		`CHK(v, 1'b0)
		access(1'b1, 1'b0, 32'h00001050, 32'h0);
		`CHK(q, 32'h0000000a)
		@(posedge sys_clk);
		int_event_in <= 32'h00000033;
		@(posedge sys_clk);
		int_event_in <= 32'h0;
		access(1'b1, 1'b0, 32'h00001080, 32'h0);
		`CHK(q, 32'h00000033)
		access(1'b1, 1'b0, 32'h00001084, 32'h0);
		`CHK(q, 32'h00000003)
		access(1'b1, 1'b1, 32'h00001084, 32'h00000001);
		access(1'b1, 1'b0, 32'h00001080, 32'h0);
		`CHK(q, 32'h00000032)
		// an event in the very cycle of its clear must survive it
		fork
			access(1'b1, 1'b1, 32'h00001084, 32'h00000002);
			begin
				@(posedge sys_clk);
				int_event_in <= 32'h00000002;
				@(posedge sys_clk);
				int_event_in <= 32'h0;
			end
		join
		access(1'b1, 1'b0, 32'h00001080, 32'h0);
		`CHK(q, 32'h00000032)
		// ordinary reset must spare the sticky fields
		@(posedge sys_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		#1;
		`CHK({subsystem_device_alias, host_ctrl_value}, {16'ha5a5, 32'h0000000a})
		`CHK({dv_timestamp_boost_en, iso_rx_mask_hi}, {1'b1, 32'h0})
		access(1'b0, 1'b0, 32'hf8, 32'h0);
		`CHK(q, 32'ha5a55a5a)
		@(posedge sys_clk);
		pcie_reset_n <= 1'b0;
		@(posedge sys_clk);
		#1;
		`CHK(fundamental_reset_n, 1'b0)
		@(posedge sys_clk);
		pcie_reset_n <= 1'b1;
		global_reset_n <= 1'b0;
		@(posedge sys_clk);
		#1;
		`CHK(fundamental_reset_n, 1'b0)
		@(posedge sys_clk);
		global_reset_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		#1;
		`CHK(fundamental_reset_n, 1'b1)
		`CHK({subsystem_device_alias, subsystem_maker_alias, host_ctrl_value}, 64'h0)
		`CHK({dv_timestamp_boost_en, priority_arb_en, accel_phy_notify}, 3'b000)
		give_verdict();
	end
endmodule : tb
